// File: logic/tvi_pkg.sv
// Constants, carrier types and state encodings of the vectored interrupt unit
package tvi_pkg;

    // ========================================
    // Register map
    localparam logic [7:0] IDX_ENABLE_MAIN = 8'hA8;
    localparam logic [7:0] IDX_PRIORITY_MAIN = 8'hB8;
    localparam logic [7:0] IDX_REQUEST_FLAGS = 8'hC0;
    localparam logic [7:0] IDX_PORT_ENABLE = 8'hE8;
    localparam logic [7:0] IDX_PORT_POLARITY = 8'hE9;
    localparam logic [7:0] IDX_PORT_PRIORITY = 8'hF8;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] MAIN_PRIORITY_MASK = 8'h1F;

    // Register select codes
    localparam logic [2:0] SEL_NONE = 3'h0;
    localparam logic [2:0] SEL_ENABLE_MAIN = 3'h1;
    localparam logic [2:0] SEL_PRIORITY_MAIN = 3'h2;
    localparam logic [2:0] SEL_REQUEST_FLAGS = 3'h3;
    localparam logic [2:0] SEL_PORT_ENABLE = 3'h4;
    localparam logic [2:0] SEL_PORT_POLARITY = 3'h5;
    localparam logic [2:0] SEL_PORT_PRIORITY = 3'h6;

    // ========================================
    // Bit positions in the main enable and priority registers
    localparam int unsigned GLOBAL_EN_BIT = 7;
    localparam int unsigned UART_BIT = 4;
    localparam int unsigned TIMER_B_BIT = 3;
    localparam int unsigned EXT_B_BIT = 2;
    localparam int unsigned TIMER_A_BIT = 1;
    localparam int unsigned EXT_A_BIT = 0;

    // ========================================
    // Sources in polling order, position 0 polled first
    localparam int unsigned SRC_COUNT = 13;
    localparam int unsigned PORT_LINES = 8;
    localparam int unsigned POS_EXT_A = 0;
    localparam int unsigned POS_TIMER_A = 2;
    localparam int unsigned POS_EXT_B = 4;
    localparam int unsigned POS_TIMER_B = 7;
    localparam int unsigned POS_UART = 10;
    // Poll position of port lines 2 to 9
    localparam int unsigned PORT_POS [PORT_LINES] = '{5, 8, 11, 1, 3, 6, 9, 12};
    localparam logic [15:0] VECTOR_TABLE [SRC_COUNT] = '{
        16'h0003, 16'h0053, 16'h000B, 16'h005B, 16'h0013, 16'h003B, 16'h0063,
        16'h001B, 16'h0043, 16'h006B, 16'h0023, 16'h004B, 16'h0073};

    // ========================================
    // Wake-up clock hold
    localparam int unsigned WAKE_DELAY_OSC = 1536;
    localparam int unsigned OSC_PERIOD_NS = 8;
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned WAKE_CYCLES =
        (WAKE_DELAY_OSC * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WAKE_CNT_WIDTH = 11;

    // ========================================
    // Carriers and states
    typedef struct packed {
        logic ext_a;
        logic ext_b;
        logic timer_a;
        logic timer_b;
        logic uart;
    } tvi_sources_type;

    typedef struct packed {
        logic req;
        logic high;
        logic [15:0] vector;
    } tvi_offer_type;

    typedef enum logic [1:0] {
        OFFER_QUIET = 2'b00,
        OFFER_POSTED = 2'b01,
        OFFER_SETTLE = 2'b10
    } tvi_offer_state_type;

    typedef enum logic {
        PWR_RUN = 1'b0,
        PWR_WAKE_HOLD = 1'b1
    } tvi_power_state_type;

    function automatic logic [9:0] tvi_byte_addr(input logic [7:0] idx);
        return {idx, 2'b00};
    endfunction

endpackage

// File: logic/tvi_arbiter.sv
// Fixed-order winner search for high and low priority sources
module tvi_arbiter
    import tvi_pkg::*;
(
    input wire logic [SRC_COUNT-1:0] pending,
    input wire logic [SRC_COUNT-1:0] high_level,
    output logic hi_valid,
    output logic [3:0] hi_index,
    output logic lo_valid,
    output logic [3:0] lo_index
);

    // ========================================
    // Lowest set position wins
    function automatic logic [3:0] first_set(input logic [SRC_COUNT-1:0] vec);
        logic [3:0] pos;
        pos = 4'h0;
        for (int i = SRC_COUNT - 1; i >= 0; i--) begin
            if (vec[i]) begin
                pos = 4'(i);
            end
        end
        return pos;
    endfunction

    always_comb begin
        hi_valid = |(pending & high_level);
        lo_valid = |(pending & ~high_level);
        hi_index = first_set(pending & high_level);
        lo_index = first_set(pending & ~high_level);
    end

endmodule // tvi_arbiter

// File: logic/tvi_interrupt_unit.sv
// Two-level vectored interrupt controller with APB register access
// What this block does
// - Takes requests from ten external lines, two timers and the UART.
// - Each source has a fixed vector; ties resolve in a fixed polling order.
// - Global enable bit 7 of main enable register gates every source.
// - Main enable bits 4..0 enable UART, timer b, ext b, timer a, ext a.
// - Port enable register bits 7..0 enable port lines 9 down to 2.
// - Each source has a priority bit; port priority holds lines 9..2.
// - Main priority bits 4..0 for UART..ext a; bits 7..5 unused.
// - High priority pending wins over low priority pending.
// - A running low level routine is preempted only by high level.
// - A running high level routine is never preempted.
// - Port pins serve as the inputs of external lines 2 to 9.
// - An enabled port line at its active level wakes from power-down.
// - Polarity register sets lines 9..2 active high (1) or low (0).
// - Enabled line sets its sticky request flag; only software clears it.
// - Port lines are level sensitive, active for one cycle before recognized.
// - A recognized port request is served no sooner than the next cycle.
// - After a wake-up the core clock stays held for 1536 oscillator periods.
// - In idle, an enabled interrupt eligible for an offer drives the idle exit.
module tvi_interrupt_unit
    import tvi_pkg::*;
#(
    parameter int unsigned ADDR_WIDTH = 12
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire tvi_sources_type core_sources,
    input wire logic [PORT_LINES-1:0] port_pins,
    output tvi_offer_type offer,
    input wire logic offer_ack,
    input wire logic irq_return,
    input wire logic idle_active,
    output logic idle_exit,
    input wire logic power_down,
    output logic wake_event,
    output logic cpu_clock_hold
);

    // ========================================
    // Elaboration check
    generate
        if (ADDR_WIDTH < 11) begin : g_addr_check
            $error("ADDR_WIDTH must be at least 11");
        end
    endgenerate

    // ========================================
    // Module state
    typedef struct packed {
        logic [7:0] enable_main;
        logic [7:0] priority_main;
        logic [7:0] flags;
        logic [7:0] port_enable;
        logic [7:0] polarity;
        logic [7:0] port_priority;
        logic [7:0] line_prev;
        tvi_offer_state_type offer_state;
        tvi_offer_type offer;
        logic active_hi;
        logic active_lo;
        tvi_power_state_type pwr_state;
        logic [WAKE_CNT_WIDTH-1:0] wake_count;
        logic [31:0] rdata;
        logic slverr;
        logic idle_exit;
        logic wake;
    } tvi_state_type;

    localparam logic [WAKE_CNT_WIDTH-1:0] WAKE_LAST =
        WAKE_CNT_WIDTH'(WAKE_CYCLES - 1);
    localparam logic [WAKE_CNT_WIDTH-1:0] WAKE_ONE = WAKE_CNT_WIDTH'(1);

    tvi_state_type st;
    tvi_state_type next_st;

    logic [SRC_COUNT-1:0] pending;
    logic [SRC_COUNT-1:0] high_level;
    logic hi_valid;
    logic lo_valid;
    logic [3:0] hi_index;
    logic [3:0] lo_index;
    logic [PORT_LINES-1:0] line_act;
    logic [7:0] flag_clear;
    logic [2:0] sel;
    logic setup_phase;
    logic wr_access;
    logic eligible;
    logic pick_high;
    logic [3:0] pick_index;
    logic after_ret_hi;
    logic after_ret_lo;

    // ========================================
    // Address decode
    function automatic logic [2:0] reg_select(input logic [ADDR_WIDTH-1:0] addr);
        logic [2:0] code;
        code = SEL_NONE;
        if (addr[ADDR_WIDTH-1:10] == '0) begin
            unique case (addr[9:0])
                tvi_byte_addr(IDX_ENABLE_MAIN): code = SEL_ENABLE_MAIN;
                tvi_byte_addr(IDX_PRIORITY_MAIN): code = SEL_PRIORITY_MAIN;
                tvi_byte_addr(IDX_REQUEST_FLAGS): code = SEL_REQUEST_FLAGS;
                tvi_byte_addr(IDX_PORT_ENABLE): code = SEL_PORT_ENABLE;
                tvi_byte_addr(IDX_PORT_POLARITY): code = SEL_PORT_POLARITY;
                tvi_byte_addr(IDX_PORT_PRIORITY): code = SEL_PORT_PRIORITY;
                default: code = SEL_NONE;
            endcase
        end
        return code;
    endfunction

    // ========================================
    // Winner search
    tvi_arbiter u_arbiter (
        .pending(pending),
        .high_level(high_level),
        .hi_valid(hi_valid),
        .hi_index(hi_index),
        .lo_valid(lo_valid),
        .lo_index(lo_index)
    );

    // ========================================
    // Next state
    always_comb begin
        next_st = st;
        next_st.idle_exit = 1'b0;
        next_st.wake = 1'b0;
        sel = reg_select(paddr);
        setup_phase = psel && !penable;
        wr_access = psel && penable && pwrite && pstrb[0];

        line_act = ~(port_pins ^ st.polarity);
        next_st.line_prev = line_act;

        // Sticky request flags; a set in the clearing cycle wins
        flag_clear = 8'h00;
        if (wr_access && sel == SEL_REQUEST_FLAGS) begin
            flag_clear = ~pwdata[7:0];
        end
        next_st.flags = (st.flags & ~flag_clear)
            | (line_act & st.line_prev & st.port_enable);

        if (wr_access) begin
            unique case (sel)
                SEL_ENABLE_MAIN: next_st.enable_main = pwdata[7:0];
                SEL_PRIORITY_MAIN: next_st.priority_main =
                    pwdata[7:0] & MAIN_PRIORITY_MASK;
                SEL_PORT_ENABLE: next_st.port_enable = pwdata[7:0];
                SEL_PORT_POLARITY: next_st.polarity = pwdata[7:0];
                SEL_PORT_PRIORITY: next_st.port_priority = pwdata[7:0];
                default: next_st.slverr = st.slverr;
            endcase
        end

        // Read data captured in the setup cycle
        if (setup_phase) begin
            next_st.slverr = (sel == SEL_NONE);
            next_st.rdata = 32'h0000_0000;
            unique case (sel)
                SEL_ENABLE_MAIN: next_st.rdata[7:0] = st.enable_main;
                SEL_PRIORITY_MAIN: next_st.rdata[7:0] = st.priority_main;
                SEL_REQUEST_FLAGS: next_st.rdata[7:0] = st.flags;
                SEL_PORT_ENABLE: next_st.rdata[7:0] = st.port_enable;
                SEL_PORT_POLARITY: next_st.rdata[7:0] = st.polarity;
                SEL_PORT_PRIORITY: next_st.rdata[7:0] = st.port_priority;
                default: next_st.rdata = 32'h0000_0000;
            endcase
        end

        // Pending and priority in polling order
        pending = '0;
        high_level = '0;
        pending[POS_EXT_A] = core_sources.ext_a & st.enable_main[EXT_A_BIT];
        pending[POS_TIMER_A] = core_sources.timer_a & st.enable_main[TIMER_A_BIT];
        pending[POS_EXT_B] = core_sources.ext_b & st.enable_main[EXT_B_BIT];
        pending[POS_TIMER_B] = core_sources.timer_b & st.enable_main[TIMER_B_BIT];
        pending[POS_UART] = core_sources.uart & st.enable_main[UART_BIT];
        high_level[POS_EXT_A] = st.priority_main[EXT_A_BIT];
        high_level[POS_TIMER_A] = st.priority_main[TIMER_A_BIT];
        high_level[POS_EXT_B] = st.priority_main[EXT_B_BIT];
        high_level[POS_TIMER_B] = st.priority_main[TIMER_B_BIT];
        high_level[POS_UART] = st.priority_main[UART_BIT];
        for (int i = 0; i < PORT_LINES; i++) begin
            // Registered flags serve one cycle after recognition
            pending[PORT_POS[i]] = st.flags[i] & st.port_enable[i];
            high_level[PORT_POS[i]] = st.port_priority[i];
        end
        if (!st.enable_main[GLOBAL_EN_BIT]) begin
            pending = '0;
        end

        // Nesting: high runs block all, low runs admit only high
        if (st.active_hi) begin
            eligible = 1'b0;
        end else if (st.active_lo) begin
            eligible = hi_valid;
        end else begin
            eligible = hi_valid || lo_valid;
        end
        pick_high = hi_valid;
        pick_index = hi_valid ? hi_index : lo_index;

        // Return pops the innermost level
        after_ret_hi = st.active_hi;
        after_ret_lo = st.active_lo;
        if (irq_return) begin
            if (st.active_hi) begin
                after_ret_hi = 1'b0;
            end else begin
                after_ret_lo = 1'b0;
            end
        end
        next_st.active_hi = after_ret_hi;
        next_st.active_lo = after_ret_lo;

        // Request offered to the core
        unique case (st.offer_state)
            OFFER_QUIET: begin
                if (eligible) begin
                    next_st.offer.req = 1'b1;
                    next_st.offer.high = pick_high;
                    next_st.offer.vector = VECTOR_TABLE[pick_index];
                    next_st.offer_state = OFFER_POSTED;
                end
            end
            OFFER_POSTED: begin
                if (offer_ack) begin
                    next_st.offer.req = 1'b0;
                    next_st.offer_state = OFFER_SETTLE;
                    if (st.offer.high) begin
                        next_st.active_hi = 1'b1;
                    end else begin
                        next_st.active_lo = 1'b1;
                    end
                end else if (eligible) begin
                    next_st.offer.high = pick_high;
                    next_st.offer.vector = VECTOR_TABLE[pick_index];
                end else begin
                    next_st.offer.req = 1'b0;
                    next_st.offer_state = OFFER_QUIET;
                end
            end
            OFFER_SETTLE: begin
                next_st.offer_state = OFFER_QUIET;
            end
            default: begin
                next_st.offer.req = 1'b0;
                next_st.offer_state = OFFER_QUIET;
            end
        endcase

        // Idle ends when an enabled interrupt is eligible to be offered
        next_st.idle_exit = idle_active && eligible;

        // Power-down wake and clock hold
        unique case (st.pwr_state)
            PWR_RUN: begin
                if (power_down && |(line_act & st.port_enable)) begin
                    next_st.wake = 1'b1;
                    next_st.wake_count = WAKE_LAST;
                    next_st.pwr_state = PWR_WAKE_HOLD;
                end
            end
            PWR_WAKE_HOLD: begin
                if (st.wake_count == '0) begin
                    next_st.pwr_state = PWR_RUN;
                end else begin
                    next_st.wake_count = st.wake_count - WAKE_ONE;
                end
            end
        endcase
    end

    // ========================================
    // State register
    always_ff @(posedge mclk) begin
        if (rst) begin
            st <= '0;
            st.enable_main <= RESET_BYTE;
            st.flags <= RESET_BYTE;
        end else begin
            st <= next_st;
        end
    end

    // ========================================
    // Outputs
    assign pready = psel && penable;
    assign prdata = st.rdata;
    assign pslverr = st.slverr;
    assign offer = st.offer;
    assign idle_exit = st.idle_exit;
    assign wake_event = st.wake;
    assign cpu_clock_hold = (st.pwr_state == PWR_WAKE_HOLD);

endmodule // tvi_interrupt_unit

// File: tb/tvi_interrupt_unit_props.sv
// Port-level checker for the vectored interrupt unit
module tvi_interrupt_unit_props
    import tvi_pkg::*;
#(
    parameter int unsigned ADDR_WIDTH = 12
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire tvi_offer_type offer,
    input wire logic offer_ack,
    input wire logic irq_return,
    input wire logic idle_active,
    input wire logic idle_exit,
    input wire logic power_down,
    input wire logic wake_event,
    input wire logic cpu_clock_hold
);
    timeunit 1ns;
    timeprecision 100ps;
    // ========================================
    // Shadow of the active levels
    logic hi_act;
    logic lo_act;
    logic [11:0] hold_cnt;
    logic mapped;
    assign mapped = paddr inside {12'h2A0, 12'h2E0, 12'h300, 12'h3A0, 12'h3A4, 12'h3E0};
    always_ff @(posedge mclk) begin
        if (rst) begin
            hi_act <= 1'b0;
            lo_act <= 1'b0;
            hold_cnt <= '0;
        end else begin
            if (offer.req && offer_ack && offer.high) hi_act <= 1'b1;
            else if (irq_return) hi_act <= 1'b0;
            if (offer.req && offer_ack && !offer.high) lo_act <= 1'b1;
            else if (irq_return && !hi_act) lo_act <= 1'b0;
            hold_cnt <= cpu_clock_hold ? hold_cnt + 12'h001 : 12'h000;
        end
    end
    // ========================================
    // Properties
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_accept;
        offer.req && offer_ack;
    endsequence
    sequence s_wake_rise;
        $rose(wake_event);
    endsequence
    a_pready_access: assert property (pready == (psel && penable))
        else $error("pready not tied to access phase");
    a_unmapped_err: assert property (psel && penable |-> pslverr == !mapped)
        else $error("slave error does not match address");
    a_upper_zero: assert property (psel && penable |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_accept_drop: assert property (s_accept |=> !offer.req)
        else $error("offer still posted after accept");
    a_vector_form: assert property (offer.req |-> offer.vector[2:0] == 3'h3 && offer.vector <= 16'h0073)
        else $error("offer vector outside table");
    a_high_blocks: assert property (hi_act |-> !offer.req)
        else $error("offer while high routine runs");
    a_low_admits: assert property (lo_act |-> !offer.req || offer.high)
        else $error("low offer while low routine runs");
    a_wake_cause: assert property (s_wake_rise |-> $past(power_down) ##[0:1] cpu_clock_hold)
        else $error("wake without power-down or hold");
    a_hold_length: assert property ($fell(cpu_clock_hold) |-> hold_cnt == 12'h600)
        else $error("clock hold length wrong");
    a_idle_cause: assert property (idle_exit |-> $past(idle_active))
        else $error("idle exit outside idle");
endmodule // tvi_interrupt_unit_props

bind tvi_interrupt_unit tvi_interrupt_unit_props #(.ADDR_WIDTH(ADDR_WIDTH)) u_props (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .offer(offer),
    .offer_ack(offer_ack), .irq_return(irq_return), .idle_active(idle_active),
    .idle_exit(idle_exit), .power_down(power_down), .wake_event(wake_event),
    .cpu_clock_hold(cpu_clock_hold));

// File: tb/tvi_core_model.sv
// Core model that accepts vectored offers and signals returns
module tvi_core_model
    import tvi_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire tvi_offer_type offer,
    input wire logic [7:0] ack_delay,
    input wire logic ret_req,
    output logic offer_ack,
    output logic irq_return,
    output int got_count,
    output logic [15:0] got_vec,
    output logic got_high
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] wait_cnt;
    // ========================================
    // Accept after a programmable wait
    always @(posedge mclk) begin
        offer_ack <= 1'b0;
        irq_return <= ret_req;
        if (rst) begin
            wait_cnt <= '0;
            got_count <= 0;
        end else if (offer.req === 1'b1 && offer_ack !== 1'b1) begin
            if (wait_cnt >= ack_delay) begin
                offer_ack <= 1'b1;
                got_count <= got_count + 1;
                got_vec <= offer.vector;
                got_high <= offer.high;
                wait_cnt <= '0;
            end else begin
                wait_cnt <= wait_cnt + 8'h01;
            end
        end else begin
            wait_cnt <= '0;
        end
    end
endmodule // tvi_core_model

// File: tb/tb.sv
// Self-checking testbench of the vectored interrupt unit
module tb
    import tvi_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [11:0] A_EN = {2'b00, IDX_ENABLE_MAIN, 2'b00};
    localparam logic [11:0] A_PRI = {2'b00, IDX_PRIORITY_MAIN, 2'b00};
    localparam logic [11:0] A_FLG = {2'b00, IDX_REQUEST_FLAGS, 2'b00};
    localparam logic [11:0] A_PEN = {2'b00, IDX_PORT_ENABLE, 2'b00};
    localparam logic [11:0] A_POL = {2'b00, IDX_PORT_POLARITY, 2'b00};
    localparam logic [11:0] A_PPR = {2'b00, IDX_PORT_PRIORITY, 2'b00};
    logic mclk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    tvi_sources_type src;
    tvi_offer_type offer;
    logic [7:0] pins, ack_delay;
    logic offer_ack, irq_return, idle_active, idle_exit, power_down, wake_event, hold, ret_req;
    logic [15:0] got_vec;
    logic got_high;
    int got_count, c;
    int n_errors = 0;
    int compares = 0;
    tvi_interrupt_unit u_tvi_interrupt_unit (.mclk(mclk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_sources(src),
        .port_pins(pins), .offer(offer), .offer_ack(offer_ack), .irq_return(irq_return),
        .idle_active(idle_active), .idle_exit(idle_exit), .power_down(power_down),
        .wake_event(wake_event), .cpu_clock_hold(hold));
    tvi_core_model u_tvi_core_model (.mclk(mclk), .rst(rst), .offer(offer),
        .ack_delay(ack_delay), .ret_req(ret_req), .offer_ack(offer_ack),
        .irq_return(irq_return), .got_count(got_count), .got_vec(got_vec), .got_high(got_high));
    // ========================================
    // Shared tasks
    task check(input string what, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
        @(posedge mclk);
        {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, 24'h0, d, s};
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 4'hF);
    endtask
    task rdc(input string what, input logic [11:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00, 4'hF);
        check(what, rd, {24'h0, exp});
    endtask
    task wait_ack;
        while (got_count == c) @(negedge mclk);
        check("accept count", got_count, c + 1);
        c = got_count;
        @(posedge mclk);
    endtask
    task ret;
        @(posedge mclk);
        ret_req <= 1'b1;
        @(posedge mclk);
        ret_req <= 1'b0;
    endtask
    task set_src(input logic [4:0] v);
        @(posedge mclk);
        src <= tvi_sources_type'(v);
    endtask
    // ========================================
    // Scenarios
    task t_regs;
        logic [11:0] a [6];
        logic [7:0] m [6];
        a = '{A_EN, A_PRI, A_FLG, A_PEN, A_POL, A_PPR};
        m = '{8'h9F, 8'h1F, 8'h00, 8'h9F, 8'h9F, 8'h9F};
        for (int i = 0; i < 6; i++) begin
            rdc("reset value", a[i], 8'h00);
            wr(a[i], 8'h9F);
            rdc("readback", a[i], m[i]);
            wr(a[i], 8'h00);
        end
        apb(1'b1, A_PEN, 8'h5A, 4'hE);
        rdc("strobe off", A_PEN, 8'h00);
        apb(1'b0, 12'h004, 8'h00, 4'hF);
        check("slave error", err, 1);
        check("unmapped data", rd, 0);
        $display("test regs done");
    endtask
    task t_order;
        logic [15:0] v [5];
        logic [4:0] m [5];
        v = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023};
        m = '{5'h10, 5'h04, 5'h08, 5'h02, 5'h01};
        wr(A_EN, 8'h1F);
        set_src(5'h1F);
        c = got_count;
        repeat (20) @(negedge mclk);
        check("gated count", got_count, c);
        check("gated offer", offer.req, 0);
        wr(A_EN, 8'h9F);
        for (int i = 0; i < 5; i++) begin
            wait_ack;
            check("order vector", got_vec, v[i]);
            set_src(src & ~m[i]);
            ret;
        end
        $display("test order done");
    endtask
    task t_prio;
        ack_delay <= 8'd3;
        wr(A_PRI, 8'h18);
        set_src(5'h11);
        wait_ack;
        check("high first", got_vec, 16'h0023);
        check("high level", got_high, 1);
        set_src(5'h12);
        repeat (20) @(negedge mclk);
        check("no nesting", got_count, c);
        ret;
        wait_ack;
        check("high over low", got_vec, 16'h001B);
        set_src(5'h10);
        ret;
        wait_ack;
        check("low served", got_vec, 16'h0003);
        set_src(5'h18);
        repeat (20) @(negedge mclk);
        check("low not nested", got_count, c);
        set_src(5'h19);
        wait_ack;
        check("preempt", got_vec, 16'h0023);
        set_src(5'h00);
        ret;
        ret;
        wr(A_PRI, 8'h00);
        ack_delay <= 8'd0;
        $display("test priority done");
    endtask
    task t_port;
        logic [7:0] b;
        wr(A_EN, 8'h80);
        wr(A_POL, 8'hAA);
        pins <= 8'h55;
        wr(A_PEN, 8'hFF);
        for (int k = 0; k < 8; k++) begin
            b = 8'h01 << k;
            @(posedge mclk);
            pins <= 8'h55 ^ b;
            @(posedge mclk);
            pins <= 8'h55;
            rdc("short level", A_FLG, 8'h00);
            @(posedge mclk);
            pins <= 8'h55 ^ b;
            wait_ack;
            check("port vector", got_vec, VECTOR_TABLE[PORT_POS[k]]);
            pins <= 8'h55;
            rdc("sticky flag", A_FLG, b);
            wr(A_FLG, 8'h00);
            rdc("flag cleared", A_FLG, 8'h00);
            ret;
        end
        wr(A_PEN, 8'h00);
        $display("test port done");
    endtask
    task t_wake;
        int n;
        n = 0;
        wr(A_EN, 8'h00);
        wr(A_PEN, 8'h01);
        @(posedge mclk);
        power_down <= 1'b1;
        pins <= 8'h54;
        while (hold !== 1'b1 && n < 10) begin
            @(negedge mclk);
            n++;
        end
        check("wake seen", hold, 1);
        check("wake pulse", wake_event, 1);
        @(posedge mclk);
        pins <= 8'h55;
        power_down <= 1'b0;
        n = 0;
        while (hold === 1'b1 && n < 2000) begin
            @(negedge mclk);
            n++;
        end
        check("hold cycles", n, 1536);
        wr(A_FLG, 8'h00);
        wr(A_PEN, 8'h00);
        $display("test wake done");
    endtask
    task t_idle;
        int n;
        n = 0;
        wr(A_EN, 8'h81);
        idle_active <= 1'b1;
        set_src(5'h10);
        while (idle_exit !== 1'b1 && n < 10) begin
            @(negedge mclk);
            n++;
        end
        check("idle exit", idle_exit, 1);
        wait_ack;
        idle_active <= 1'b0;
        set_src(5'h00);
        ret;
        $display("test idle done");
    endtask
    task results;
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ========================================
    // Clock, reset, sequence and watchdog
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata, pstrb} = {4'h8, 12'h0, 32'h0, 4'hF};
        {src, pins, ack_delay, idle_active, power_down, ret_req} = {13'h00FF, 11'h000};
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        t_regs;
        t_order;
        t_prio;
        t_port;
        t_wake;
        t_idle;
        results;
    end
    initial begin
        repeat (30000) @(posedge mclk);
        n_errors++;
        results;
    end
endmodule // tb
